//--- core/pllcfg_fabric.sv
// Purpose: Fabric controller: APB registers drive loop settings and report lock.
// Assumes: APB master on core_clk; slave answers with no wait states.
// Notes: Unmapped addresses read zero and flag pslverr.
`timescale 1ns/1ns
module pllcfg_fabric
	import pllcfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	pllcfg_if.fabric_end link
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] rdata;
		logic settled;
		logic loopBack;
	} pllcfg_fab_type;
	pllcfg_fab_type st_r, st_nxt;
	logic access;

	assign access = psel & penable;

	// Register decode and status tracking
	always_comb begin
		st_nxt = st_r;
		if (access && pwrite && paddr == REG_CTRL) begin
			st_nxt.ctrl = pwdata;
			st_nxt.settled = 1'b0;
		end
		// Lock seen in the same cycle as a write wins over its clear
		if (link.lock) begin
			st_nxt.settled = 1'b1;
		end
		// Read word is captured in the setup cycle so prdata comes from a flop
		if (psel && !penable && !pwrite) begin
			if (paddr == REG_CTRL) begin
				st_nxt.rdata = st_r.ctrl;
			end else if (paddr == REG_STAT) begin
				st_nxt.rdata = '0;
				st_nxt.rdata[STAT_LOCK_BIT] = link.lock;
				st_nxt.rdata[STAT_SETTLED_BIT] = st_r.settled & link.lock;
				st_nxt.rdata[STAT_MULT_LSB +: MULT_W] =
					MULT_W'(st_r.ctrl[CTRL_FBDIV_LSB +: FB_DIV_W]) + 7'h01;
			end else begin
				st_nxt.rdata = '0;
			end
		end
		// Deskew loop: secondary clock routed back as feedback
		st_nxt.loopBack = link.secondaryClockOut;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.ctrl <= CTRL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Registered read data; status is one cycle old by the access edge
	assign prdata = st_r.rdata;
	assign pready = 1'b1;
	assign pslverr = access && paddr != REG_CTRL && paddr != REG_STAT;
	// Settings go straight from the control register; software picks codes
	assign link.sleepControl = st_r.ctrl[CTRL_SLEEP_BIT];
	assign link.inputRangeSelect = st_r.ctrl[CTRL_RANGE_BIT];
	assign link.feedbackDividerCode = st_r.ctrl[CTRL_FBDIV_LSB +: FB_DIV_W];
	assign link.output1DividerCode = st_r.ctrl[CTRL_OUTDIV_LSB +: OUT_DIV_W];
	assign link.outputRangeSelect = st_r.ctrl[CTRL_OSC_LSB +: OSC_W];
	assign link.clockDelayCode = st_r.ctrl[CTRL_DELAY_LSB +: DELAY_W];
	assign link.loopReturnIn = st_r.loopBack;
endmodule

//--- core/pllcfg_if.sv
// Purpose: Connection between the loop end and the fabric controller end.
// Assumes: All settings are levels, synchronous to the core clock.
// Notes: No bidirectional pins; the reference clock is a plain input on the loop end.
`timescale 1ns/1ns
interface pllcfg_if;
	import pllcfg_pkg::*;
	logic sleepControl;
	logic [FB_DIV_W-1:0] feedbackDividerCode;
	logic [OUT_DIV_W-1:0] output1DividerCode;
	logic inputRangeSelect;
	logic [OSC_W-1:0] outputRangeSelect;
	logic [DELAY_W-1:0] clockDelayCode;
	logic lock;
	logic primaryClockOut;
	logic secondaryClockOut;
	logic loopReturnIn;
	modport loop_end (
		input sleepControl, feedbackDividerCode, output1DividerCode, inputRangeSelect,
		input outputRangeSelect, clockDelayCode, loopReturnIn,
		output lock, primaryClockOut, secondaryClockOut
	);
	modport fabric_end (
		output sleepControl, feedbackDividerCode, output1DividerCode, inputRangeSelect,
		output outputRangeSelect, clockDelayCode, loopReturnIn,
		input lock, primaryClockOut, secondaryClockOut
	);
endinterface

//--- core/pllcfg_loop.sv
// Purpose: Behavioural loop end: takes settings, makes two divided clocks and lock.
// Assumes: Reference clock stands in as an input sampled on core_clk.
// Notes: Clocks are modelled as toggles of an internal oscillator count.
// Operation
// - Feedback code plus one gives multiplier
// - Output1 code sets primary clock division
// - Range bit zero for fast reference
// - Output range select uses listed codes
// - Delay code is sign and magnitude
// - Lock output high once loop locked
// - Reference kept in range by user
// - Feedback, reference, routed selects are configuration-only
// - Global network selects are configuration-only
// - Secondary clock returns as feedback
// - Sleep low powers loop down
`timescale 1ns/1ns
module pllcfg_loop
	import pllcfg_pkg::*;
#(
	parameter int LOCK_WAIT = LOCK_CYCLES,
	parameter logic FEEDBACK_SOURCE_SELECT = 1'b0,
	parameter logic REFERENCE_SOURCE_SELECT = 1'b0,
	parameter logic ROUTED_OUTPUT_SELECT = 1'b0,
	parameter logic [1:0] PLL_GLOBAL_SELECT = 2'h0,
	parameter logic [1:0] GLOBAL_ROOT_SELECT = 2'h0
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic referenceClockIn,
	pllcfg_if.loop_end link,
	output logic globalClockOut
);
	typedef enum logic [1:0] {LP_SLEEP, LP_ACQUIRE, LP_LOCKED} pllcfg_lstate_type;
	typedef struct packed {
		pllcfg_lstate_type st;
		logic [LOCK_CNT_W-1:0] cnt;
		logic [FB_DIV_W+OUT_DIV_W+OSC_W+DELAY_W:0] cfg;
		logic [OUT_DIV_W-1:0] divCnt;
		logic primary_clock_out;
		logic secondary_clock_out;
		logic lock;
	} pllcfg_loop_type;
	pllcfg_loop_type st_r, st_nxt;
	logic [FB_DIV_W+OUT_DIV_W+OSC_W+DELAY_W:0] cfgNow;
	logic [MULT_W-1:0] multiplier;
	logic [DELAY_W-2:0] delayMag;
	logic delayNeg;

	// Snapshot of every live setting except sleepControl; any change while awake restarts acquisition
	assign cfgNow = {link.inputRangeSelect, link.feedbackDividerCode, link.output1DividerCode,
		link.outputRangeSelect, link.clockDelayCode};
	assign multiplier = MULT_W'(link.feedbackDividerCode) + 7'h01;
	assign delayNeg = link.clockDelayCode[DELAY_SIGN_BIT];
	assign delayMag = link.clockDelayCode[DELAY_W-2:0];

	// Next state of the loop model
	always_comb begin
		st_nxt = st_r;
		st_nxt.cfg = cfgNow;
		case (st_r.st)
			LP_SLEEP: begin
				st_nxt.lock = 1'b0;
				st_nxt.primary_clock_out = 1'b0;
				st_nxt.secondary_clock_out = 1'b0;
				if (link.sleepControl) begin
					st_nxt.st = LP_ACQUIRE;
					st_nxt.cnt = '0;
				end
			end
			LP_ACQUIRE: begin
				st_nxt.lock = 1'b0;
				st_nxt.cnt = st_r.cnt + 16'h0001;
				if (st_r.cnt >= LOCK_CNT_W'(LOCK_WAIT - 1)) begin
					st_nxt.st = LP_LOCKED;
				end
			end
			default: begin
				st_nxt.lock = 1'b1;
			end
		endcase
		// Settings change drops lock; the loop must settle again
		if (st_r.st != LP_SLEEP && cfgNow != st_r.cfg) begin
			st_nxt.st = LP_ACQUIRE;
			st_nxt.cnt = '0;
			st_nxt.lock = 1'b0;
		end
		if (!link.sleepControl) begin
			st_nxt.st = LP_SLEEP;
			st_nxt.lock = 1'b0;
		end
		// Oscillator stand-in: reference-paced, primary divided by code plus one
		if (st_r.st != LP_SLEEP && referenceClockIn) begin
			st_nxt.secondary_clock_out = ~st_r.secondary_clock_out;
			if (st_r.divCnt >= link.output1DividerCode) begin
				st_nxt.divCnt = '0;
				st_nxt.primary_clock_out = ~st_r.primary_clock_out;
			end else begin
				st_nxt.divCnt = st_r.divCnt + 6'h01;
			end
		end
	end

	// State register; lock and clocks are low after reset
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.lock = st_r.lock;
	assign link.primaryClockOut = st_r.primary_clock_out;
	assign link.secondaryClockOut = st_r.secondary_clock_out;
	// Fixed selects: parameters only, user logic cannot reach them
	assign globalClockOut = (PLL_GLOBAL_SELECT[0] ^ GLOBAL_ROOT_SELECT[0])
		? (ROUTED_OUTPUT_SELECT ? st_r.secondary_clock_out : link.loopReturnIn) : st_r.primary_clock_out;
endmodule

//--- core/pllcfg_pkg.sv
// Purpose: Shared constants and types for the loop configuration link.
// Assumes: One core clock of 100 MHz.
// Notes: Field widths and codes of the loop settings live here.
package pllcfg_pkg;
	localparam int FB_DIV_W = 6;
	localparam int OUT_DIV_W = 6;
	localparam int OSC_W = 3;
	localparam int DELAY_W = 5;
	localparam int MULT_W = 7;
	localparam logic [6:0] MULT_MAX = 7'h40;
	localparam logic [2:0] OSC_400_1000 = 3'h0;
	localparam logic [2:0] OSC_200_400 = 3'h1;
	localparam logic [2:0] OSC_100_200 = 3'h3;
	localparam logic [2:0] OSC_50_100 = 3'h5;
	localparam logic [2:0] OSC_20_50 = 3'h7;
	localparam int DELAY_STEP_PS = 250;
	localparam int DELAY_MAX_STEPS = 15;
	localparam int DELAY_SIGN_BIT = 4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOCK_TIME_NS = 2000;
	localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CNT_W = 16;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CTRL_RANGE_BIT = 1;
	localparam int CTRL_FBDIV_LSB = 8;
	localparam int CTRL_OUTDIV_LSB = 16;
	localparam int CTRL_OSC_LSB = 24;
	localparam int CTRL_DELAY_LSB = 27;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_SETTLED_BIT = 1;
	localparam int STAT_MULT_LSB = 8;
endpackage

//--- tb/pllcfg_props.sv
// Purpose: Concurrent checks on the loop settings link.
// Assumes: One clock domain; settings are levels from the fabric end.
// Notes: Lock bounds assume a small lock wait; they do not depend on the reference.
`timescale 1ns/1ns
module pllcfg_props
	import pllcfg_pkg::*;
#(
	parameter int LOCK_WAIT = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sleepControl,
	input wire logic [FB_DIV_W-1:0] feedbackDividerCode,
	input wire logic [OUT_DIV_W-1:0] output1DividerCode,
	input wire logic inputRangeSelect,
	input wire logic [OSC_W-1:0] outputRangeSelect,
	input wire logic [DELAY_W-1:0] clockDelayCode,
	input wire logic lock,
	input wire logic primaryClockOut,
	input wire logic secondaryClockOut,
	input wire logic loopReturnIn
);
	localparam int LOCK_MAX = LOCK_WAIT + 4;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Wake-up step and the acquire that must follow it
	sequence s_wake;
		$rose(sleepControl);
	endsequence
	sequence s_acquire;
		##[1:LOCK_MAX] (lock || !sleepControl);
	endsequence
	// Two sampled cycles asleep: the loop model has left its running state
	sequence s_asleep;
		!sleepControl ##1 !sleepControl;
	endsequence
	property p_clk_sleep;
		s_asleep |=> !primaryClockOut && !secondaryClockOut;
	endproperty
	property p_loop_ret;
		loopReturnIn == $past(secondaryClockOut);
	endproperty
	property p_rng_chg;
		$changed(inputRangeSelect) |=> !lock;
	endproperty
	property p_sleep_off;
		!sleepControl |=> !lock;
	endproperty
	property p_lock_soon;
		s_wake |-> s_acquire;
	endproperty
	// Lock may only rise while awake, and only if the loop was also awake LOCK_WAIT cycles earlier
	property p_lock_wait;
		$rose(lock) |-> sleepControl && $past(sleepControl, LOCK_WAIT);
	endproperty
	property p_lock_hold;
		lock && sleepControl && $stable({feedbackDividerCode, output1DividerCode,
			inputRangeSelect, outputRangeSelect, clockDelayCode}) |=> lock;
	endproperty
	property p_fb_chg;
		$changed(feedbackDividerCode) |=> !lock;
	endproperty
	property p_out_chg;
		$changed(output1DividerCode) |=> !lock;
	endproperty
	property p_dly_chg;
		$changed(clockDelayCode) |=> !lock;
	endproperty
	property p_osc_chg;
		$changed(outputRangeSelect) |=> !lock;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("lock high while asleep");
	a_lock_soon: assert property (p_lock_soon) else $error("lock not reached after wake");
	a_lock_wait: assert property (p_lock_wait) else $error("lock rose too early");
	a_lock_hold: assert property (p_lock_hold) else $error("lock dropped while steady");
	a_fb_chg: assert property (p_fb_chg) else $error("lock kept over feedback change");
	a_out_chg: assert property (p_out_chg) else $error("lock kept over divider change");
	a_dly_chg: assert property (p_dly_chg) else $error("lock kept over delay change");
	a_osc_chg: assert property (p_osc_chg) else $error("lock kept over range change");
	a_clk_sleep: assert property (p_clk_sleep) else $error("clock running asleep");
	a_loop_ret: assert property (p_loop_ret) else $error("return path not secondary_clock_out");
	a_rng_chg: assert property (p_rng_chg) else $error("lock kept over input range");
endmodule

//--- tb/test_pll_config_interface.sv
// Purpose: Drives the fabric end over APB and checks link and status words.
// Assumes: Zero-wait slave, but the master still waits for pready.
// Notes: Lock wait shortened to 4 so each acquire takes a few cycles.
`timescale 1ns/1ns
module test_pll_config_interface import pllcfg_pkg::*;;
	logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, reference_clock_in = 0, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, w;
	logic pready, pslverr;
	logic c1, c2, gclk;
	logic [5:0] fb;
	localparam int LW = 4;
	int n, lk;
	logic [4:0] dlyT [5] = '{5'h1f, 5'h0f, 5'h10, 5'h00, 5'h11};
	logic [2:0] oscT [5] = '{OSC_400_1000, OSC_200_400, OSC_100_200, OSC_50_100, OSC_20_50};
	int bad_count = 0, tests_run = 0, cyc = 0;
	pllcfg_if link_bus();
	pllcfg_loop #(.LOCK_WAIT(LW)) pllcfg_loop_i(.core_clk(core_clk), .rstn(rstn),
		.referenceClockIn(reference_clock_in), .link(link_bus.loop_end), .globalClockOut(gclk));
	pllcfg_fabric pllcfg_fabric_i(.core_clk(core_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link_bus.fabric_end));
	pllcfg_props #(.LOCK_WAIT(LW)) pllcfg_props_i(.core_clk(core_clk), .rstn(rstn),
		.primaryClockOut(link_bus.primaryClockOut), .loopReturnIn(link_bus.loopReturnIn),
		.secondaryClockOut(link_bus.secondaryClockOut),
		.sleepControl(link_bus.sleepControl), .feedbackDividerCode(link_bus.feedbackDividerCode),
		.output1DividerCode(link_bus.output1DividerCode), .lock(link_bus.lock),
		.inputRangeSelect(link_bus.inputRangeSelect), .clockDelayCode(link_bus.clockDelayCode),
		.outputRangeSelect(link_bus.outputRangeSelect));
	initial forever #5 core_clk = ~core_clk;
	// Reference high every other cycle; the clocks step on it, but lock timing still counts core_clk
	always @(posedge core_clk) begin
		reference_clock_in <= ~reference_clock_in;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		apb(0, REG_CTRL, 0);
		chk("ctrl reset", CTRL_RESET, rd);
		apb(0, REG_STAT, 0);
		chk("stat reset", 32'h100, rd);
		$display("test reset done");
		// Every output range code, with boundary divider and delay codes
		for (int i = 0; i < 5; i++) begin
			fb = (i == 4) ? 6'h3f : 6'(i * 15);
			w = {dlyT[i], oscT[i], 2'h0, 6'(i), 2'h0, fb, 6'h0, i[0], 1'b1};
			apb(1, REG_CTRL, w);
			// Settings reach the loop on the write edge itself; lock falls at the next
			repeat (2) @(posedge core_clk);
			chk("lock drop", 0, {31'h0, link_bus.lock});
			for (lk = 0; lk < 100 && link_bus.lock !== 1'b1; lk++) @(posedge core_clk);
			chk("lock time", 32'(LW + 1), 32'(lk));
			chk("lock", 1, {31'h0, link_bus.lock});
			chk("link", w, {link_bus.clockDelayCode, link_bus.outputRangeSelect, 2'h0,
				link_bus.output1DividerCode, 2'h0, link_bus.feedbackDividerCode, 6'h0,
				link_bus.inputRangeSelect, link_bus.sleepControl});
			// Sync to a primary toggle, then count secondary toggles to the next one
			c1 = link_bus.primaryClockOut;
			for (lk = 0; lk < 200 && link_bus.primaryClockOut === c1; lk++) @(posedge core_clk);
			c1 = link_bus.primaryClockOut;
			c2 = link_bus.secondaryClockOut;
			n = 0;
			for (lk = 0; lk < 200 && link_bus.primaryClockOut === c1; lk++) begin
				@(posedge core_clk);
				if (link_bus.secondaryClockOut !== c2) begin
					n++;
					c2 = link_bus.secondaryClockOut;
				end
			end
			chk("clk ratio", 32'(i + 1), 32'(n));
			chk("global", {31'h0, link_bus.primaryClockOut}, {31'h0, gclk});
			apb(0, REG_STAT, 0);
			chk("stat", ((32'(fb) + 1) << 8) | 32'h3, rd);
		end
		$display("test settings done");
		apb(1, REG_CTRL, 0);
		repeat (3) @(posedge core_clk);
		apb(0, REG_STAT, 0);
		chk("stat asleep", 32'h100, rd);
		chk("clk asleep", 0, {30'h0, link_bus.primaryClockOut, link_bus.secondaryClockOut});
		apb(1, REG_STAT, 32'hffffffff);
		chk("stat write err", 0, {31'h0, er});
		apb(0, 8'h08, 0);
		chk("unmapped", 32'h1, {rd[30:0], er});
		apb(0, REG_CTRL, 0);
		chk("ctrl kept", 32'h0, rd);
		$display("test refusal done");
		end_sim();
	end
endmodule
